// ==== design/pfc_fault_gate_manager.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// saturating qualify timer: out is high once in has been high LIMIT cycles
module qualify_timer
	import pfc_fault_pkg::*;
#(
	parameter int LIMIT = 1
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic level,
	output logic      qual
);
	localparam logic [CNT_W-1:0] LIM = CNT_W'(LIMIT);
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;

	// count while level holds, restart on any break
	assign cnt_d = !level ? '0 : (cnt_q == LIM) ? cnt_q : cnt_q + 1'b1;
	assign qual  = level && (cnt_q == LIM);

	// counter state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// fault qualification and gate enable for the boost stage
module pfc_fault_gate_manager
	import pfc_fault_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RSTN,
	input  wire logic        PEAK_CURRENT_LIMIT,
	input  wire logic        BROWNOUT_LOW,
	input  wire logic        BROWNOUT_HIGH,
	input  wire logic        OPEN_LOOP_PROTECT,
	input  wire logic        OVER_VOLTAGE_PROTECT,
	input  wire logic        OVER_VOLTAGE_RELEASE,
	input  wire logic        SUPPLY_UNDERVOLTAGE_LOCKOUT,
	input  wire logic        MIN_OFF_INTERVAL,
	input  wire logic        ON_REQUEST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	output logic             IRQ,
	output logic             GATE_DRIVE
);
	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	localparam int NSYNC = 7;
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] sync1_q;
	logic [NSYNC-1:0] sync2_q;
	logic             peak_s;
	logic             bo_low_s;
	logic             bo_high_s;
	logic             oloop_s;
	logic             ovp_s;
	logic             ov_rel_s;
	logic             uvlo_s;

	assign pin_raw = {SUPPLY_UNDERVOLTAGE_LOCKOUT, OVER_VOLTAGE_RELEASE, OVER_VOLTAGE_PROTECT,
		OPEN_LOOP_PROTECT, BROWNOUT_HIGH, BROWNOUT_LOW, PEAK_CURRENT_LIMIT};
	assign {uvlo_s, ov_rel_s, ovp_s, oloop_s, bo_high_s, bo_low_s, peak_s} = sync2_q;

	// two flops per comparator flag
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// deglitch and blanking timers
	logic peak_ok;
	logic brown_ok;
	logic oloop_ok;
	logic ovp_ok;

	qualify_timer #(.LIMIT(PEAK_BLANK_CYC)) u_peak (
		.clk(CLK), .rst_n(RSTN), .level(peak_s), .qual(peak_ok));
	qualify_timer #(.LIMIT(BROWN_BLANK_CYC)) u_brown (
		.clk(CLK), .rst_n(RSTN), .level(bo_low_s), .qual(brown_ok));
	qualify_timer #(.LIMIT(OLOOP_BLANK_CYC)) u_oloop (
		.clk(CLK), .rst_n(RSTN), .level(oloop_s), .qual(oloop_ok));
	qualify_timer #(.LIMIT(OVP_BLANK_CYC)) u_ovp (
		.clk(CLK), .rst_n(RSTN), .level(ovp_s), .qual(ovp_ok));

	////////////////////////////////////////////////////////////////////////////
	// fault latches and soft restart
	logic             brown_q;
	logic             oloop_q;
	logic             ovp_q;
	logic             brown_d;
	logic             oloop_d;
	logic             ovp_d;
	logic             uvlo_q;
	logic [CNT_W-1:0] rst_cnt_q;
	logic [CNT_W-1:0] rst_cnt_d;
	logic             restart_pend;
	logic             restart_go;

	// set wins over the release condition; lockout wipes the brownout, open-loop and over-voltage faults
	assign brown_d = !uvlo_s && (brown_ok || (brown_q && !bo_high_s));
	assign oloop_d = !uvlo_s && (oloop_ok || (oloop_q && oloop_s));
	assign ovp_d = !uvlo_s && (ovp_ok || (ovp_q && !ov_rel_s));
	// a restart begins when a brownout or open-loop fault clears or lockout ends
	assign restart_go = (brown_q && !brown_d) || (oloop_q && !oloop_d) || (uvlo_q && !uvlo_s);
	assign restart_pend = (rst_cnt_q != '0);
	assign rst_cnt_d = uvlo_s ? '0 : restart_go ? CNT_W'(RESTART_CYC) :
		restart_pend ? rst_cnt_q - 1'b1 : rst_cnt_q;

	// fault state
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			brown_q   <= 1'b0;
			oloop_q   <= 1'b0;
			ovp_q     <= 1'b0;
			uvlo_q    <= 1'b1;
			rst_cnt_q <= '0;
		end else begin
			brown_q   <= brown_d;
			oloop_q   <= oloop_d;
			ovp_q     <= ovp_d;
			uvlo_q    <= uvlo_s;
			rst_cnt_q <= rst_cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// cycle logic: on latch, current-limit latch, gate
	logic on_q;
	logic cl_q;
	logic on_d;
	logic cl_d;
	logic gate_d;
	logic gate_q;
	logic ctrl_en;

	assign on_d = !MIN_OFF_INTERVAL && (on_q || ON_REQUEST);
	assign cl_d = !MIN_OFF_INTERVAL && (cl_q || peak_ok);
	// active high drive, blocked by any fault, restart, lockout or software;
	// uvlo_q covers the cycle between lockout exit and the restart count loading
	assign gate_d = on_d && !cl_d && !brown_q && !oloop_q && !ovp_q && !restart_pend
		&& !uvlo_s && !uvlo_q && ctrl_en;

	// latches and drive flop
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			on_q   <= 1'b0;
			cl_q   <= 1'b0;
			gate_q <= 1'b0;
		end else begin
			on_q   <= on_d;
			cl_q   <= cl_d;
			gate_q <= gate_d;
		end
	end

	assign GATE_DRIVE = gate_q;

	////////////////////////////////////////////////////////////////////////////
	// apb slave and interrupt registers
	apb_req_s    req;
	faults_s     live;
	faults_s     evt;
	faults_s     evt_q;
	faults_s     evt_d;
	faults_s     mask_q;
	logic [31:0] ctrl_q;
	logic [31:0] rdata_q;
	logic [31:0] rd_mux;
	logic        hit_ctrl;
	logic        hit_state;
	logic        hit_evt;
	logic        hit_mask;
	logic        mapped;
	logic        wr_acc;
	logic        setup;

	assign req       = '{PSEL, PENABLE, PWRITE, PADDR, PWDATA};
	assign hit_ctrl  = (req.addr == CTRL_OFS);
	assign hit_state = (req.addr == STATE_OFS);
	assign hit_evt   = (req.addr == EVENT_OFS);
	assign hit_mask  = (req.addr == MASK_OFS);
	assign mapped    = hit_ctrl || hit_state || hit_evt || hit_mask;
	assign setup     = req.sel && !req.enable;
	assign wr_acc    = req.sel && req.enable && req.write && mapped;
	assign ctrl_en   = ctrl_q[CTRL_EN_BIT];

	// live fault view and one-cycle rising events
	assign live = '{uvlo: uvlo_s, ovp: ovp_q, oloop: oloop_q, brown: brown_q, peak: cl_q};
	assign evt  = '{uvlo: uvlo_s && !uvlo_q, ovp: ovp_d && !ovp_q,
		oloop: oloop_d && !oloop_q, brown: brown_d && !brown_q, peak: cl_d && !cl_q};
	// write one to clear; a new event in the same cycle stays set
	assign evt_d = (evt_q & ~((wr_acc && hit_evt) ? faults_s'(req.wdata[FAULT_W-1:0]) : '0))
		| evt;

	assign rd_mux = hit_ctrl ? ctrl_q :
		hit_state ? {25'h000_0000, restart_pend, gate_q, live} :
		hit_evt ? {27'h000_0000, evt_q} :
		hit_mask ? {27'h000_0000, mask_q} : 32'h0000_0000;

	assign PREADY  = 1'b1;
	assign PSLVERR = req.sel && req.enable && !mapped;
	assign PRDATA  = rdata_q;
	assign IRQ     = |(evt_q & mask_q);

	// register file; read data captured in the setup cycle
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ctrl_q  <= CTRL_RST;
			evt_q   <= EVENT_RST;
			mask_q  <= MASK_RST;
			rdata_q <= 32'h0000_0000;
		end else begin
			evt_q <= evt_d;
			if (wr_acc && hit_ctrl) begin
				ctrl_q <= {31'h0000_0000, req.wdata[CTRL_EN_BIT]};
			end
			if (wr_acc && hit_mask) begin
				mask_q <= faults_s'(req.wdata[FAULT_W-1:0]);
			end
			if (setup) begin
				rdata_q <= rd_mux;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_brown_release;
		brown_q && bo_high_s && !uvlo_s;
	endsequence

	sequence s_restart_hold;
		!GATE_DRIVE [*8];
	endsequence

	property p_peak_deglitch;
		@(posedge CLK) disable iff (!RSTN)
		$rose(peak_ok) |-> $past(peak_s, 1) && $past(peak_s, 24) && $past(peak_s, 12);
	endproperty
	a_peak_deglitch: assert property (p_peak_deglitch)
		else $error("peak current qualified before blanking time");

	property p_peak_cut;
		@(posedge CLK) disable iff (!RSTN)
		peak_ok && !MIN_OFF_INTERVAL |=> !GATE_DRIVE && cl_q;
	endproperty
	a_peak_cut: assert property (p_peak_cut)
		else $error("gate not cut on peak current");

	property p_brown_restart;
		@(posedge CLK) disable iff (!RSTN)
		s_brown_release |=> !brown_q && restart_pend ##1 s_restart_hold;
	endproperty
	a_brown_restart: assert property (p_brown_restart)
		else $error("brownout release did not start a soft restart");

	property p_oloop_off;
		@(posedge CLK) disable iff (!RSTN)
		oloop_ok && !uvlo_s |=> oloop_q ##1 !GATE_DRIVE;
	endproperty
	a_oloop_off: assert property (p_oloop_off)
		else $error("open loop did not power down");

	property p_ovp_hold;
		@(posedge CLK) disable iff (!RSTN)
		ovp_q && !ov_rel_s && !uvlo_s |=> ovp_q && !GATE_DRIVE;
	endproperty
	a_ovp_hold: assert property (p_ovp_hold)
		else $error("over voltage released early");

	property p_gate_cause;
		@(posedge CLK) disable iff (!RSTN)
		GATE_DRIVE |-> $past(on_d) && $past(ctrl_en) && !$past(cl_d);
	endproperty
	a_gate_cause: assert property (p_gate_cause)
		else $error("gate high without an on request");

	property p_uvlo_low;
		@(posedge CLK) disable iff (!RSTN)
		uvlo_s |=> !GATE_DRIVE;
	endproperty
	a_uvlo_low: assert property (p_uvlo_low)
		else $error("gate driven during supply lockout");

	property p_minoff_clear;
		@(posedge CLK) disable iff (!RSTN)
		MIN_OFF_INTERVAL |=> !on_q && !cl_q && !GATE_DRIVE;
	endproperty
	a_minoff_clear: assert property (p_minoff_clear)
		else $error("minimum off interval did not clear latches");

	property p_fault_block;
		@(posedge CLK) disable iff (!RSTN)
		(brown_q || oloop_q || ovp_q || restart_pend) |=> !GATE_DRIVE;
	endproperty
	a_fault_block: assert property (p_fault_block)
		else $error("gate active during fault or restart");
endmodule

// ==== design/pfc_fault_pkg.sv ====
package pfc_fault_pkg;

	// clock and timing
	localparam int CLK_PERIOD_NS   = 8;
	localparam int PEAK_BLANK_NS   = 200;
	localparam int BROWN_BLANK_NS  = 20000;
	localparam int OLOOP_BLANK_NS  = 1000;
	localparam int OVP_BLANK_NS    = 12000;
	localparam int RESTART_NS      = 10000;
	localparam int PEAK_BLANK_CYC  = (PEAK_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BROWN_BLANK_CYC = (BROWN_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OLOOP_BLANK_CYC = (OLOOP_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OVP_BLANK_CYC   = (OVP_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESTART_CYC     = (RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W           = 12;

	// register map, byte addresses
	localparam logic [11:0] CTRL_OFS     = 12'h000;
	localparam logic [11:0] STATE_OFS    = 12'h004;
	localparam logic [11:0] EVENT_OFS    = 12'h008;
	localparam logic [11:0] MASK_OFS     = 12'h00C;

	// field positions
	localparam int CTRL_EN_BIT     = 0;
	localparam int STATE_GATE_BIT  = 5;
	localparam int STATE_RST_BIT   = 6;
	localparam int FAULT_W         = 5;

	// reset values
	localparam logic [31:0] CTRL_RST  = 32'h0000_0001;
	localparam logic [4:0]  EVENT_RST = 5'h0_0;
	localparam logic [4:0]  MASK_RST  = 5'h0_0;

	// fault flags, one bit per fault kind, same layout in state, event and mask
	typedef struct packed {
		logic uvlo;
		logic ovp;
		logic oloop;
		logic brown;
		logic peak;
	} faults_s;

	// apb request as seen by the slave
	typedef struct packed {
		logic        sel;
		logic        enable;
		logic        write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} apb_req_s;

endpackage

// ==== verification/pfc_fault_gate_manager_tb.sv ====
`timescale 1ns/1ps
module pfc_fault_gate_manager_tb
	import pfc_fault_pkg::*;
;
	logic        clk, rst_n, min_off, on_req, cur_over, vcc_low;
	logic        psel, penable, pwrite, pready, pslverr, irq, gate, er;
	logic        pk, bl, bh, ol, ovp, rel, uv;
	logic [11:0] brown_mv, vout_mv, paddr;
	logic [31:0] pwdata, prdata, rd;
	int          err_count, check_count, cyc;

	// far side: sense comparators and power switch
	analog_front_end_model i_afe (.brown_mv(brown_mv), .vout_mv(vout_mv),
		.cur_over(cur_over), .vcc_low(vcc_low), .gate(gate), .peak_flag(pk),
		.brown_low(bl), .brown_high(bh), .oloop_flag(ol), .ovp_flag(ovp), .ovp_rel(rel),
		.uvlo_flag(uv), .switch_on());

	pfc_fault_gate_manager i_dut (.CLK(clk), .RSTN(rst_n), .PEAK_CURRENT_LIMIT(pk),
		.BROWNOUT_LOW(bl), .BROWNOUT_HIGH(bh), .OPEN_LOOP_PROTECT(ol),
		.OVER_VOLTAGE_PROTECT(ovp), .OVER_VOLTAGE_RELEASE(rel),
		.SUPPLY_UNDERVOLTAGE_LOCKOUT(uv), .MIN_OFF_INTERVAL(min_off), .ON_REQUEST(on_req),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq), .GATE_DRIVE(gate));

	// free-running clock
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: expected %h got %h", $time, exp, got);
		end
	endtask

	// gate must stay at one level for n cycles
	task automatic hold_gate(input logic exp, input int n);
		logic ok;
		ok = 1'h1;
		repeat (n) begin
			@(posedge clk);
			#1;
			if (gate !== exp) ok = 1'h0;
		end
		chk(32'h0000_0001, 32'(ok));
	endtask

	// gate must reach a level within lim cycles
	task automatic wait_gate(input logic exp, input int lim);
		int i;
		i = 0;
		while (gate !== exp && i < lim) begin
			@(posedge clk);
			#1;
			i++;
		end
		chk(32'(exp), 32'(gate));
	endtask

	// one switching cycle: min-off pulse, then on request
	task automatic pwm_cycle;
		min_off <= 1'h1;
		@(posedge clk);
		min_off <= 1'h0;
		on_req  <= 1'h1;
		@(posedge clk);
		on_req  <= 1'h0;
		@(posedge clk);
		#1;
	endtask

	// soft restart keeps the gate off before it follows the request
	task automatic restart_check;
		on_req <= 1'h1;
		hold_gate(1'h0, RESTART_CYC - 10);
		wait_gate(1'h1, 40);
		on_req <= 1'h0;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
		#1;
	endtask

	task automatic t_cycle;
		pwm_cycle();
		chk(32'h0000_0001, 32'(gate));
		min_off <= 1'h1;
		@(posedge clk);
		#1;
		on_req  <= 1'h1;
		repeat (2) @(posedge clk);
		#1;
		chk(32'h0000_0000, 32'(gate));
		min_off <= 1'h0;
		on_req  <= 1'h0;
		hold_gate(1'h0, 3);
	endtask

	task automatic t_peak;
		pwm_cycle();
		cur_over <= 1'h1;
		hold_gate(1'h1, PEAK_BLANK_CYC - 4);
		cur_over <= 1'h0;
		hold_gate(1'h1, 5);
		cur_over <= 1'h1;
		wait_gate(1'h0, PEAK_BLANK_CYC + 6);
		cur_over <= 1'h0;
		on_req <= 1'h1;
		hold_gate(1'h0, 4);
		on_req <= 1'h0;
		pwm_cycle();
		chk(32'h0000_0001, 32'(gate));
	endtask

	task automatic t_ovp;
		pwm_cycle();
		vout_mv <= 12'hAF0;
		hold_gate(1'h1, OVP_BLANK_CYC - 10);
		wait_gate(1'h0, 20);
		vout_mv <= 12'hA28;
		hold_gate(1'h0, 5);
		pwm_cycle();
		chk(32'h0000_0000, 32'(gate));
		vout_mv <= 12'h960;
		hold_gate(1'h0, 3);
		pwm_cycle();
		chk(32'h0000_0001, 32'(gate));
	endtask

	task automatic t_oloop;
		pwm_cycle();
		vout_mv <= 12'h190;
		hold_gate(1'h1, OLOOP_BLANK_CYC - 10);
		wait_gate(1'h0, 20);
		vout_mv <= 12'h960;
		restart_check();
	endtask

	task automatic t_brown;
		pwm_cycle();
		brown_mv <= 12'h320;
		hold_gate(1'h1, BROWN_BLANK_CYC - 10);
		wait_gate(1'h0, 20);
		brown_mv <= 12'h44C;
		on_req <= 1'h1;
		hold_gate(1'h0, 300);
		brown_mv <= 12'h5DC;
		restart_check();
	endtask

	task automatic t_uvlo;
		pwm_cycle();
		vcc_low <= 1'h1;
		wait_gate(1'h0, 4);
		on_req <= 1'h1;
		hold_gate(1'h0, 20);
		vcc_low <= 1'h0;
		restart_check();
	endtask

	task automatic t_regs;
		apb(1'h0, CTRL_OFS, 32'h0000_0000);
		chk(CTRL_RST, rd);
		apb(1'h0, MASK_OFS, 32'h0000_0000);
		chk(32'(MASK_RST), rd);
		apb(1'h0, 12'h010, 32'h0000_0000);
		chk(32'h0000_0001, 32'(er));
		chk(32'h0000_0000, rd);
		apb(1'h1, EVENT_OFS, 32'h0000_001F);
		apb(1'h1, MASK_OFS, 32'h0000_0001);
		chk(32'h0000_0000, 32'(irq));
		cur_over <= 1'h1;
		repeat (40) @(posedge clk);
		cur_over <= 1'h0;
		#1;
		chk(32'h0000_0001, 32'(irq));
		apb(1'h1, MASK_OFS, 32'h0000_0000);
		chk(32'h0000_0000, 32'(irq));
		apb(1'h0, EVENT_OFS, 32'h0000_0000);
		chk(32'h0000_0001, rd);
		apb(1'h1, EVENT_OFS, 32'h0000_0001);
		apb(1'h0, EVENT_OFS, 32'h0000_0000);
		chk(32'h0000_0000, rd);
		// current-limit latch still set, gate off, no restart pending
		apb(1'h0, STATE_OFS, 32'h0000_0000);
		chk(32'h0000_0001, rd);
	endtask

	// cut a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_count++;
			end_of_test();
		end
	end

	// main sequence
	initial begin
		{rst_n, min_off, on_req, cur_over, vcc_low, psel, penable, pwrite} = 8'h00;
		brown_mv = 12'h5DC;
		vout_mv = 12'h960;
		paddr   = 12'h000;
		pwdata  = 32'h0000_0000;
		repeat (20) @(posedge clk);
		rst_n <= 1'h1;
		#1;
		restart_check();
		t_cycle();
		t_peak();
		t_ovp();
		t_oloop();
		t_brown();
		t_uvlo();
		t_regs();
		end_of_test();
	end
endmodule

// ==== verification/pfc_front_end_model.sv ====
`timescale 1ns/1ps
module analog_front_end_model (
	input  wire logic [11:0] brown_mv,
	input  wire logic [11:0] vout_mv,
	input  wire logic        cur_over,
	input  wire logic        vcc_low,
	input  wire logic        gate,
	output logic             peak_flag,
	output logic             brown_low,
	output logic             brown_high,
	output logic             oloop_flag,
	output logic             ovp_flag,
	output logic             ovp_rel,
	output logic             uvlo_flag,
	output logic             switch_on
);
	// comparators on the sensed levels, thresholds in millivolts
	assign peak_flag  = cur_over;
	assign brown_low  = brown_mv < 12'h3E8;
	assign brown_high = brown_mv > 12'h4E2;
	assign oloop_flag = vout_mv < 12'h1F4;
	assign ovp_flag  = vout_mv > 12'hA8C;
	assign ovp_rel   = vout_mv < 12'h9C4;
	assign uvlo_flag = vcc_low;
	// boost switch conducts while the gate is high
	assign switch_on = gate;
endmodule
